/* logic/drive_alarm_map.svh */
`ifndef DRIVE_ALARM_MAP_SVH
`define DRIVE_ALARM_MAP_SVH
// ==========================================
// Register offsets
`define ALM_WORD_OFS 8'h00
`define ALM_CLEAR_OFS 8'h04
`define OUT_CFG_OFS 8'h08
`define OUT_OWNER_OFS 8'h0c
`define MAX_ACCEL_OFS 8'h10
`define DRV_STATUS_OFS 8'h14
`define DRV_CTRL_OFS 8'h18
`define IRQ_STATUS_OFS 8'h1c
`define IRQ_CLEAR_OFS 8'h20
`define IRQ_ENABLE_OFS 8'h24
`define FAULT_MASK_OFS 8'h28
`define IO_DIR_OFS 8'h2c
// ==========================================
// Field positions
`define CFG_CODE_LSB 0
`define CFG_POINT_LSB 2
`define CTRL_ENABLE_BIT 0
`define CTRL_STOP_BIT 1
`define CTRL_KILL_BIT 2
`define CTRL_GP_BIT 3
// ==========================================
// Reset values and limits
`define CFG_CODE_RST 2'h1
`define CFG_POINT_RST 3'h0
`define MAX_ACCEL_RST 16'h0fa0
`define MAX_ACCEL_MIN 16'h0001
`define MAX_ACCEL_MAX 16'h7fbd
`define FAULT_MASK_RST 16'h00f8
`define IO_DIR_RST 4'h0
`endif

/* logic/drive_alarm_pkg.sv */
package drive_alarm_pkg;
	typedef enum logic [4:0] {
		OWN_ALARM = 5'b00001,
		OWN_BRAKE = 5'b00010,
		OWN_MOTION = 5'b00100,
		OWN_TACH = 5'b01000,
		OWN_GP = 5'b10000
	} owner_t;
	typedef enum logic [1:0] {
		CODE_CLOSE_ON_FAULT = 2'h1,
		CODE_OPEN_ON_FAULT = 2'h2,
		CODE_NOT_ALARM = 2'h3
	} alarm_code_t;
	typedef struct packed {
		alarm_code_t code;
		logic [2:0] point;
	} out_cfg_t;
	typedef struct packed {
		logic brake;
		logic motion;
		logic tach;
	} fn_levels_t;
endpackage

/* logic/drive_alarm_word_and_output.sv */
// Overview of operation
// R1 - Alarm word readable as one 16-bit word, one bit per condition.
// R2 - Simultaneous conditions report the OR of their codes.
// R3 - Bit 0100 is hall-sensor or open-winding failure, per variant.
// R4 - Any drive-fault bit turning active disables the motor.
// R5 - Clear drops bits, but present conditions stay set; motor stays off.
// R6 - Max accel setting 1..32701 steps of 0.167 rps/s.
// R7 - Max decel used on limit during move and on stop or kill.
// R8 - Output signals drive-fault alarm by default.
// R9 - Code 1: output closed low while fault present, else open.
// R10 - Code 2: output open high while fault present, else closed.
// R11 - Code 3: output not driven from fault state.
// R12 - Exactly one of five functions owns the output.
// R13 - Writing code 1 or 2 takes the output over.
// R14 - Brake or motion assignment forces alarm code to 3.
// R15 - Second field picks I/O point 1 to 4 for the alarm.
// R16 - Host configures the point as output before selecting it.
// R17 - Energized reads low/closed, de-energized high/open.
// R18 - Alarm bits stay latched until a clear.
// R19 - Fault-present is the OR of fault-class bits, every cycle.
//
// Decided for this implementation: the register addresses and the APB slave port.
module drive_alarm_word_and_output #(
	parameter int NUM_IO = 4
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [15:0] alarm_cond,
	input wire logic limit_in,
	input wire logic move_active,
	input wire drive_alarm_pkg::fn_levels_t fn_levels,
	output logic motor_enable,
	output logic decel_hold,
	output logic [15:0] decel_rate,
	output logic fault_output_pin,
	output logic [NUM_IO-1:0] io_out,
	output logic [NUM_IO-1:0] io_oe,
	output logic irq
);
`include "drive_alarm_map.svh"

	// ==========================================
	// Pin synchronisers
	logic [16:0] sync1, sync2, sync3, filt;
	logic [16:0] next_filt;
	always_comb begin
		next_filt = filt;
		for (int i = 0; i < 17; i++) begin
			// Glitch of one sample is ignored
			if (sync2[i] == sync3[i]) begin
				next_filt[i] = sync3[i];
			end
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1 <= '0;
			sync2 <= '0;
			sync3 <= '0;
			filt <= '0;
		end else begin
			sync1 <= {limit_in, alarm_cond};
			sync2 <= sync1;
			sync3 <= sync2;
			filt <= next_filt;
		end
	end
	logic [15:0] cond;
	logic limit_now;
	assign cond = filt[15:0];
	assign limit_now = filt[16];

	// ==========================================
	// APB decode
	logic wr_en, rd_phase, hit;
	assign wr_en = psel & penable & pready & pwrite;
	assign rd_phase = psel & penable & ~pready;
	always_comb begin
		case (paddr)
			`ALM_WORD_OFS, `ALM_CLEAR_OFS, `OUT_CFG_OFS, `OUT_OWNER_OFS,
			`MAX_ACCEL_OFS, `DRV_STATUS_OFS, `DRV_CTRL_OFS, `IRQ_STATUS_OFS,
			`IRQ_CLEAR_OFS, `IRQ_ENABLE_OFS, `FAULT_MASK_OFS, `IO_DIR_OFS: hit = 1'b1;
			default: hit = 1'b0;
		endcase
	end
	logic w_clear, w_cfg, w_owner, w_accel, w_ctrl, w_iclr, w_ien, w_mask, w_dir;
	assign w_clear = wr_en & (paddr == `ALM_CLEAR_OFS) & pwdata[0];
	assign w_cfg = wr_en & (paddr == `OUT_CFG_OFS);
	assign w_owner = wr_en & (paddr == `OUT_OWNER_OFS);
	assign w_accel = wr_en & (paddr == `MAX_ACCEL_OFS);
	assign w_ctrl = wr_en & (paddr == `DRV_CTRL_OFS);
	assign w_iclr = wr_en & (paddr == `IRQ_CLEAR_OFS);
	assign w_ien = wr_en & (paddr == `IRQ_ENABLE_OFS);
	assign w_mask = wr_en & (paddr == `FAULT_MASK_OFS);
	assign w_dir = wr_en & (paddr == `IO_DIR_OFS);

	// ==========================================
	// Alarm word and motor enable
	logic [15:0] alarm_word, fault_mask, next_alarm_word, next_fault_mask;
	logic motor_en_reg, next_motor_en;
	logic fault_present, fault_now;
	// R19 fault OR
	assign fault_present = |(alarm_word & fault_mask);
	assign fault_now = |(cond & fault_mask);
	always_comb begin
		// R18 latched bits
		next_alarm_word = alarm_word;
		// R5 clear keeps present
		if (w_clear) begin
			next_alarm_word = '0;
		end
		// R2 OR of codes
		// R3 bit 0100 from its input
		next_alarm_word = next_alarm_word | cond;
		next_fault_mask = w_mask ? pwdata[15:0] : fault_mask;
		next_motor_en = motor_en_reg;
		if (w_ctrl) begin
			next_motor_en = pwdata[`CTRL_ENABLE_BIT];
		end
		// R4 fault disables
		if (fault_now) begin
			next_motor_en = 1'b0;
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			alarm_word <= '0;
			fault_mask <= `FAULT_MASK_RST;
			motor_en_reg <= 1'b0;
		end else begin
			alarm_word <= next_alarm_word;
			fault_mask <= next_fault_mask;
			motor_en_reg <= next_motor_en;
		end
	end

	// ==========================================
	// Output ownership
	drive_alarm_pkg::out_cfg_t cfg, next_cfg;
	drive_alarm_pkg::owner_t owner, next_owner;
	logic [NUM_IO-1:0] io_dir, next_io_dir;
	logic gp_level, next_gp_level;
	logic forced, next_forced;
	logic [1:0] wcode;
	logic [2:0] wpoint;
	assign wcode = pwdata[`CFG_CODE_LSB +: 2];
	assign wpoint = pwdata[`CFG_POINT_LSB +: 3];
	always_comb begin
		next_cfg = cfg;
		next_owner = owner;
		next_forced = 1'b0;
		next_io_dir = w_dir ? pwdata[NUM_IO-1:0] : io_dir;
		next_gp_level = w_ctrl ? pwdata[`CTRL_GP_BIT] : gp_level;
		// R15 point 0 dedicated, 1..4
		if (w_cfg && wcode != 2'h0 && wpoint <= 3'(NUM_IO)) begin
			next_cfg.code = drive_alarm_pkg::alarm_code_t'(wcode);
			next_cfg.point = wpoint;
			// R13 take over output
			if (wcode != 2'h3) begin
				next_owner = drive_alarm_pkg::OWN_ALARM;
			end else if (owner == drive_alarm_pkg::OWN_ALARM) begin
				next_owner = drive_alarm_pkg::OWN_GP;
			end
		end
		// R12 single owner
		if (w_owner) begin
			case (pwdata[2:0])
				3'h1: next_owner = drive_alarm_pkg::OWN_BRAKE;
				3'h2: next_owner = drive_alarm_pkg::OWN_MOTION;
				3'h3: next_owner = drive_alarm_pkg::OWN_TACH;
				3'h4: next_owner = drive_alarm_pkg::OWN_GP;
				default: next_owner = owner;
			endcase
			// R14 forced to code 3
			if (pwdata[2:0] >= 3'h1 && pwdata[2:0] <= 3'h4
					&& cfg.code != drive_alarm_pkg::CODE_NOT_ALARM) begin
				next_cfg.code = drive_alarm_pkg::CODE_NOT_ALARM;
				next_forced = 1'b1;
			end
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			// R8 alarm by default
			cfg <= '{code: drive_alarm_pkg::alarm_code_t'(`CFG_CODE_RST), point: `CFG_POINT_RST};
			owner <= drive_alarm_pkg::OWN_ALARM;
			io_dir <= `IO_DIR_RST;
			gp_level <= 1'b1;
			forced <= 1'b0;
		end else begin
			cfg <= next_cfg;
			owner <= next_owner;
			io_dir <= next_io_dir;
			gp_level <= next_gp_level;
			forced <= next_forced;
		end
	end

	// ==========================================
	// Pin levels, 0 = closed / energized
	logic level, next_pin;
	logic [NUM_IO-1:0] next_io_out, next_io_oe;
	always_comb begin
		case (owner)
			drive_alarm_pkg::OWN_ALARM: begin
				case (cfg.code)
					// R9 closed on fault
					drive_alarm_pkg::CODE_CLOSE_ON_FAULT: level = ~fault_present;
					// R10 open on fault
					drive_alarm_pkg::CODE_OPEN_ON_FAULT: level = fault_present;
					// R11 not driven by fault
					default: level = gp_level;
				endcase
			end
			drive_alarm_pkg::OWN_BRAKE: level = fn_levels.brake;
			drive_alarm_pkg::OWN_MOTION: level = fn_levels.motion;
			drive_alarm_pkg::OWN_TACH: level = fn_levels.tach;
			drive_alarm_pkg::OWN_GP: level = gp_level;
			default: level = 1'b1;
		endcase
		// R17 idle is open high
		next_pin = (cfg.point == 3'h0) ? level : 1'b1;
	end
	genvar g;
	generate
		for (g = 0; g < NUM_IO; g++) begin : io_pt
			// R16 only output points driven
			assign next_io_oe[g] = (cfg.point == 3'(g + 1)) & io_dir[g];
			assign next_io_out[g] = next_io_oe[g] ? level : 1'b1;
		end
	endgenerate

	// ==========================================
	// Max accel and stop deceleration
	logic [15:0] max_accel, next_max_accel;
	logic hold_reg, next_hold, limit_d, next_limit_d;
	always_comb begin
		next_max_accel = max_accel;
		// R6 clamp to range
		if (w_accel) begin
			if (pwdata[15:0] < `MAX_ACCEL_MIN) begin
				next_max_accel = `MAX_ACCEL_MIN;
			end else if (pwdata[15:0] > `MAX_ACCEL_MAX) begin
				next_max_accel = `MAX_ACCEL_MAX;
			end else begin
				next_max_accel = pwdata[15:0];
			end
		end
		next_limit_d = limit_now;
		next_hold = hold_reg & move_active;
		// R7 stop, kill, limit
		if (move_active && ((limit_now && !limit_d)
				|| (w_ctrl && (pwdata[`CTRL_STOP_BIT] || pwdata[`CTRL_KILL_BIT])))) begin
			next_hold = 1'b1;
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			max_accel <= `MAX_ACCEL_RST;
			hold_reg <= 1'b0;
			limit_d <= 1'b0;
		end else begin
			max_accel <= next_max_accel;
			hold_reg <= next_hold;
			limit_d <= next_limit_d;
		end
	end

	// ==========================================
	// Interrupts: new alarm, fault onset, forced release
	logic [2:0] irq_stat, irq_en, next_irq_stat, next_irq_en, ev;
	logic fault_d, next_fault_d;
	assign next_fault_d = fault_present;
	assign ev = {forced, fault_present & ~fault_d, |(cond & ~alarm_word)};
	always_comb begin
		next_irq_en = w_ien ? pwdata[2:0] : irq_en;
		// Set beats a clear in the same cycle
		next_irq_stat = (irq_stat & ~(w_iclr ? pwdata[2:0] : 3'h0)) | ev;
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_stat <= '0;
			irq_en <= '0;
			fault_d <= 1'b0;
		end else begin
			irq_stat <= next_irq_stat;
			irq_en <= next_irq_en;
			fault_d <= next_fault_d;
		end
	end

	// ==========================================
	// Read mux and registered outputs
	logic [31:0] rdata, next_prdata;
	always_comb begin
		case (paddr)
			// R1 16-bit word
			`ALM_WORD_OFS: rdata = {16'h0000, alarm_word};
			`OUT_CFG_OFS: rdata = {27'h0, cfg.point, cfg.code};
			`OUT_OWNER_OFS: rdata = {27'h0, owner};
			`MAX_ACCEL_OFS: rdata = {16'h0000, max_accel};
			`DRV_STATUS_OFS: rdata = {29'h0, hold_reg, fault_present, motor_en_reg};
			`DRV_CTRL_OFS: rdata = {28'h0, gp_level, 2'h0, motor_en_reg};
			`IRQ_STATUS_OFS: rdata = {29'h0, irq_stat};
			`IRQ_ENABLE_OFS: rdata = {29'h0, irq_en};
			`FAULT_MASK_OFS: rdata = {16'h0000, fault_mask};
			`IO_DIR_OFS: rdata = {{(32 - NUM_IO){1'b0}}, io_dir};
			default: rdata = 32'h0000_0000;
		endcase
		next_prdata = (rd_phase && !pwrite) ? rdata : prdata;
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= '0;
			pready <= 1'b0;
			pslverr <= 1'b0;
			motor_enable <= 1'b0;
			decel_hold <= 1'b0;
			decel_rate <= `MAX_ACCEL_RST;
			fault_output_pin <= 1'b1;
			io_out <= '1;
			io_oe <= '0;
			irq <= 1'b0;
		end else begin
			// One wait state per transfer
			prdata <= next_prdata;
			pready <= rd_phase;
			pslverr <= rd_phase & ~hit;
			motor_enable <= next_motor_en;
			decel_hold <= next_hold;
			decel_rate <= next_max_accel;
			fault_output_pin <= next_pin;
			io_out <= next_io_out;
			io_oe <= next_io_oe;
			irq <= |(next_irq_stat & next_irq_en);
		end
	end
endmodule

/* bench/drive_alarm_props.sv */
`include "drive_alarm_map.svh"
module drive_alarm_props #(
	parameter int NUM_IO = 4
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [15:0] alarm_cond,
	input wire logic move_active,
	input wire logic motor_enable,
	input wire logic decel_hold,
	input wire logic [15:0] decel_rate,
	input wire logic [NUM_IO-1:0] io_oe
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ========
	// Checks
	chk_one_wait: assert property ($rose(psel && penable) |-> !pready ##1 pready)
		else $error("ready timing");
	chk_err_ready: assert property (pslverr |-> pready)
		else $error("error without ready");
	chk_word_width: assert property (pready && !pwrite && paddr == `ALM_WORD_OFS |-> prdata[31:16] == 16'h0000)
		else $error("alarm word wider than 16");
	chk_fault_off: assert property (alarm_cond[7] [*8] |-> !motor_enable)
		else $error("motor on during fault");
	chk_clear_keep: assert property (pready && pwrite && paddr == `ALM_CLEAR_OFS && !motor_enable |=> !motor_enable)
		else $error("clear enabled motor");
	chk_rate_range: assert property (decel_rate inside {[16'h0001:16'h7fbd]})
		else $error("rate out of range");
	chk_hold_cause: assert property ($rose(decel_hold) |-> $past(move_active))
		else $error("hold without move");
	chk_hold_end: assert property (decel_hold && !move_active |=> !decel_hold)
		else $error("hold after move");
	chk_one_owner: assert property ($onehot0(io_oe))
		else $error("two points driven");
endmodule
bind drive_alarm_word_and_output drive_alarm_props #(.NUM_IO(NUM_IO)) i_props (.pclk, .presetn,
	.psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr, .alarm_cond, .move_active,
	.motor_enable, .decel_hold, .decel_rate, .io_oe);

/* bench/apb_host.sv */
module apb_host (
	input wire logic pclk,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [7:0] paddr,
	output logic [31:0] pwdata
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
	end
	// ========
	// Transfer
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] rd_word, output logic e);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd_word = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// Stale data must not look valid
		pwdata <= ~d;
	endtask
endmodule

/* bench/drive_alarm_word_and_output_tb_top.sv */
`include "drive_alarm_map.svh"
module drive_alarm_word_and_output_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel, penable, pwrite, pready, pslverr, e;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd_word;
	logic [15:0] alarm_cond = 16'h0000;
	logic limit_in = 1'b0;
	logic move_active = 1'b0;
	drive_alarm_pkg::fn_levels_t fn_levels = '0;
	logic motor_enable, decel_hold, fault_output_pin, irq;
	logic [15:0] decel_rate;
	logic [3:0] io_out, io_oe;
	int err_count = 0;
	int n_compared = 0;
	int cycles = 0;
	drive_alarm_word_and_output i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .alarm_cond, .limit_in, .move_active,
		.fn_levels, .motor_enable, .decel_hold, .decel_rate, .fault_output_pin,
		.io_out, .io_oe, .irq);
	apb_host i_host (.pclk, .prdata, .pready, .pslverr, .psel, .penable, .pwrite, .paddr,
		.pwdata);
	initial begin
		forever #10 pclk = ~pclk;
	end
	// ========
	// Helpers
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic idle(input int n);
		repeat (n) @(negedge pclk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		i_host.xfer(1'b1, a, d, rd_word, e);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] x);
		i_host.xfer(1'b0, a, 32'h0, rd_word, e);
		cmp(rd_word, x);
	endtask
	task automatic cond(input logic [15:0] v);
		@(posedge pclk);
		alarm_cond <= v;
		idle(10);
	endtask
	task automatic drv(input logic m, input logic l);
		@(posedge pclk);
		move_active <= m;
		limit_in <= l;
		idle(8);
	endtask
	task automatic end_of_test;
		if (err_count == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// ========
	// Scenarios
	task automatic t_reset;
		rd(`OUT_CFG_OFS, 32'h1);
		rd(`MAX_ACCEL_OFS, 32'h0fa0);
		idle(1);
		cmp(32'(fault_output_pin), 32'h1);
	endtask
	task automatic t_alarm;
		wr(`IRQ_ENABLE_OFS, 32'h7);
		wr(`DRV_CTRL_OFS, 32'h1);
		cond(16'h0301);
		cond(16'h0000);
		rd(`ALM_WORD_OFS, 32'h0301);
		cond(16'h0080);
		cmp(32'({motor_enable, fault_output_pin, irq}), 32'h1);
		rd(`IRQ_STATUS_OFS, 32'h3);
		wr(`IRQ_ENABLE_OFS, 32'h0);
		wr(`IRQ_CLEAR_OFS, 32'h7);
		rd(`IRQ_STATUS_OFS, 32'h0);
		cmp(32'(irq), 32'h0);
		cond(16'h0008);
		wr(`ALM_CLEAR_OFS, 32'h1);
		rd(`ALM_WORD_OFS, 32'h0008);
		wr(`DRV_CTRL_OFS, 32'h1);
		cond(16'h0000);
		wr(`ALM_CLEAR_OFS, 32'h1);
		idle(3);
		cmp(32'({motor_enable, fault_output_pin}), 32'h1);
	endtask
	task automatic t_owner;
		wr(`OUT_CFG_OFS, 32'h2);
		idle(3);
		cmp(32'(fault_output_pin), 32'h0);
		cond(16'h0080);
		cmp(32'(fault_output_pin), 32'h1);
		cond(16'h0000);
		wr(`ALM_CLEAR_OFS, 32'h1);
		for (int k = 1; k <= 2; k++) begin
			wr(`OUT_CFG_OFS, 32'h1);
			wr(`OUT_OWNER_OFS, k);
			rd(`OUT_CFG_OFS, 32'h3);
			rd(`OUT_OWNER_OFS, 32'h1 << k);
		end
		wr(`OUT_CFG_OFS, 32'h2);
		rd(`OUT_OWNER_OFS, 32'h1);
		wr(`OUT_CFG_OFS, 32'h3);
		rd(`OUT_OWNER_OFS, 32'h10);
	endtask
	task automatic t_share;
		// Fault must not reach the pin once alarm use is off
		wr(`DRV_CTRL_OFS, 32'h8);
		cond(16'h0080);
		cmp(32'(fault_output_pin), 32'h1);
		cond(16'h0000);
		wr(`ALM_CLEAR_OFS, 32'h1);
		// Only the owning function's level may reach the pin
		for (int k = 1; k <= 3; k++) begin
			wr(`OUT_OWNER_OFS, k);
			@(posedge pclk);
			fn_levels <= drive_alarm_pkg::fn_levels_t'(~(3'h1 << (3 - k)));
			idle(3);
			cmp(32'(fault_output_pin), 32'h0);
		end
	endtask
	task automatic t_point;
		wr(`IO_DIR_OFS, 32'h8);
		wr(`OUT_CFG_OFS, 32'h11);
		wr(`OUT_CFG_OFS, 32'h15);
		wr(`OUT_CFG_OFS, 32'h10);
		rd(`OUT_CFG_OFS, 32'h11);
		idle(2);
		cmp(32'({io_oe, io_out[3]}), 32'h11);
		rd(8'h30, 32'h0);
		cmp(32'(e), 32'h1);
		wr(`OUT_CFG_OFS, 32'h1);
	endtask
	task automatic t_decel;
		wr(`MAX_ACCEL_OFS, 32'h0);
		rd(`MAX_ACCEL_OFS, 32'h1);
		wr(`MAX_ACCEL_OFS, 32'hffff);
		rd(`MAX_ACCEL_OFS, 32'h7fbd);
		for (int k = 2; k <= 4; k += 2) begin
			drv(1'b1, 1'b0);
			wr(`DRV_CTRL_OFS, k);
			idle(2);
			cmp(32'({decel_hold, decel_rate}), 32'h17fbd);
			rd(`DRV_STATUS_OFS, 32'h4);
			drv(1'b0, 1'b0);
		end
		drv(1'b1, 1'b1);
		cmp(32'(decel_hold), 32'h1);
		drv(1'b0, 1'b0);
		cmp(32'(decel_hold), 32'h0);
	endtask
	// ========
	// Main
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 20000) begin
			err_count++;
			end_of_test();
		end
	end
	initial begin
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_alarm();
		t_owner();
		t_share();
		t_point();
		t_decel();
		end_of_test();
	end
endmodule
